/* design/fssm_pkg.sv */
/*
  Constants for the flash status byte and erase-granularity address map.
  Assumes a 23-bit byte address inside a 24-bit address field.
*/
`default_nettype none
package fssm_pkg;
  // Status byte bit positions
  localparam int unsigned BUSY_POS  = 0;
  localparam int unsigned WR_EN_POS = 1;
  localparam int unsigned BP_LSB    = 2;
  localparam int unsigned BP_MSB    = 5;
  localparam int unsigned QUAD_POS  = 6;
  localparam int unsigned LOCK_POS  = 7;
  localparam logic [7:0]  STATUS_RST = 8'h00;

  // Address map
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned SECTOR_SHIFT = 12;
  localparam int unsigned HALF_SHIFT   = 15;
  localparam int unsigned BLOCK_SHIFT  = 16;
  localparam int unsigned ARRAY_MSB    = 22;
  localparam int unsigned SECTOR_W     = 11;
  localparam int unsigned HALF_W       = 8;
  localparam int unsigned BLOCK_W      = 7;
  localparam logic [7:0]  NUM_BLOCKS   = 8'h80;

  // Command codes on the decoded command port
  localparam logic [3:0] CMD_WREN   = 4'h0;
  localparam logic [3:0] CMD_WRDIS  = 4'h1;
  localparam logic [3:0] CMD_STATWR = 4'h2;
  localparam logic [3:0] CMD_PROG   = 4'h3;
  localparam logic [3:0] CMD_SECT   = 4'h4;
  localparam logic [3:0] CMD_HALF   = 4'h5;
  localparam logic [3:0] CMD_BLOCK  = 4'h6;
  localparam logic [3:0] CMD_CHIP   = 4'h7;
  localparam logic [3:0] CMD_SBLOCK = 4'h8;
  localparam logic [3:0] CMD_SBUNLK = 4'h9;
  localparam logic [3:0] CMD_ALLLK  = 4'hA;
  localparam logic [3:0] CMD_ALLUNL = 4'hB;
  localparam logic [3:0] CMD_SECWR  = 4'hC;
  localparam logic [3:0] CMD_SCHEME = 4'hD;
endpackage : fssm_pkg
`default_nettype wire

/* design/fssm_top.sv */
/*
  Status byte, write-enable latch, block protection and sector map of a serial flash.
  Assumes an outer serial front end on link_clk that delivers decoded commands,
  an array engine on core_clk that reports op_done, and a non-volatile store.
*/
// Overview of operation
// - 128 blocks of 64KB, two halves each
// - Sixteen 4KB sectors per block, 0 to 2047
// - Sector n base is n times 0x1000
// - Status byte shows busy, write enable, protection
// - Bit 0 busy during program or erase
// - Bit 1 mirrors the write-enable latch
// - Bits 2..5 protection level, writable, default 0
// - Bit 6 quad lane enable, default 0
// - Bit 7 lock with pin low makes protection bits read-only
// - Busy and latch ignore status writes
// - Protection, quad and lock bits kept non-volatile
// - Latch low rejects program and erase
// - Latch clears after disable, program, erase, status write
// - Latch clears after lock, security, scheme commands
// - Busy low means next command accepted
// - Chip erase only with protection zero
// - Pin low plus lock refuses status writes
// - Quad enable turns pins into data lanes
`timescale 1ns/1ps
`default_nettype none
module fssm_top (
  // Core clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Link side, on link_clk
  input  wire logic        link_clk,
  input  wire logic        link_cmd_valid,
  input  wire logic [3:0]  link_cmd_code,
  input  wire logic [7:0]  link_cmd_data,
  input  wire logic [23:0] link_cmd_addr,
  output logic      [7:0]  link_status_q,
  input  wire logic [1:0]  link_lane_dout,
  input  wire logic        link_lane_drive,
  output logic      [1:0]  link_lane_din_q,
  // Shared pins: write protect / lane 2, hold / lane 3
  input  wire logic        quad_data_lane2_in,
  output logic             quad_data_lane2_out,
  output logic             quad_data_lane2_oe,
  input  wire logic        quad_data_lane3_in,
  output logic             quad_data_lane3_out,
  output logic             quad_data_lane3_oe,
  output logic             hold_n_q,
  // Array engine
  output logic             op_start_q,
  output logic      [3:0]  op_kind_q,
  output logic      [23:0] op_base_q,
  output logic      [10:0] op_sector_q,
  output logic      [7:0]  op_half_q,
  output logic      [6:0]  op_block_q,
  output logic      [7:0]  op_data_q,
  input  wire logic        op_done,
  // Non-volatile store of bits 2..7
  input  wire logic [5:0]  nv_restore,
  output logic             nv_write_q,
  output logic      [5:0]  nv_value_q
);

  // Link domain: reset, command capture, toggle event
  logic        lrst_s1_q, lrst_q;
  logic        ltog_q;
  logic [3:0]  lcode_q;
  logic [7:0]  ldata_q;
  logic [23:0] laddr_q;
  logic [7:0]  lstat_s1_q;
  logic [7:0]  status;

  always_ff @(posedge link_clk) begin
    lrst_s1_q <= rst;
    lrst_q    <= lrst_s1_q;
  end

  // Held fields stay stable until the next command, so the core reads them after the toggle
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      ltog_q  <= 1'b0;
      lcode_q <= 4'h0;
      ldata_q <= 8'h00;
      laddr_q <= 24'h000000;
    end else if (link_cmd_valid) begin
      ltog_q  <= ~ltog_q;
      lcode_q <= link_cmd_code;
      ldata_q <= link_cmd_data;
      laddr_q <= link_cmd_addr;
    end
  end

  // Independent flag bits, so a per-bit two-stage sync is enough
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      lstat_s1_q    <= fssm_pkg::STATUS_RST;
      link_status_q <= fssm_pkg::STATUS_RST;
    end else begin
      lstat_s1_q    <= status;
      link_status_q <= lstat_s1_q;
    end
  end

  // Lanes drive only with quad enabled
  always_ff @(posedge link_clk) begin
    if (lrst_q) begin
      quad_data_lane2_oe  <= 1'b0;
      quad_data_lane3_oe  <= 1'b0;
      quad_data_lane2_out <= 1'b0;
      quad_data_lane3_out <= 1'b0;
      link_lane_din_q     <= 2'h0;
    end else begin
      quad_data_lane2_oe  <= link_lane_drive & link_status_q[fssm_pkg::QUAD_POS];
      quad_data_lane3_oe  <= link_lane_drive & link_status_q[fssm_pkg::QUAD_POS];
      quad_data_lane2_out <= link_lane_dout[0];
      quad_data_lane3_out <= link_lane_dout[1];
      link_lane_din_q     <= {quad_data_lane3_in, quad_data_lane2_in};
    end
  end

  // Core domain: event and pin synchronisers
  logic       ctog_s1_q, ctog_s2_q, ctog_s3_q;
  logic       wp_s1_q, wp_q;
  logic       hd_s1_q, hd_q;
  logic       exec;
  logic       busy_q, wr_en_q, restored_q;
  logic [3:0] bp_q;
  logic       quad_en_q, lock_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctog_s1_q <= 1'b0;
      ctog_s2_q <= 1'b0;
      ctog_s3_q <= 1'b0;
      wp_s1_q   <= 1'b1;
      wp_q      <= 1'b1;
      hd_s1_q   <= 1'b1;
      hd_q      <= 1'b1;
    end else begin
      ctog_s1_q <= ltog_q;
      ctog_s2_q <= ctog_s1_q;
      ctog_s3_q <= ctog_s2_q;
      wp_s1_q   <= quad_data_lane2_in;
      wp_q      <= wp_s1_q;
      hd_s1_q   <= quad_data_lane3_in;
      hd_q      <= hd_s1_q;
    end
  end

  assign exec = ctog_s2_q ^ ctog_s3_q;

  // Pin meanings fall away once the lanes carry data
  logic wp_low;
  assign wp_low = ~quad_en_q & ~wp_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_n_q <= 1'b1;
    end else begin
      hold_n_q <= quad_en_q | hd_q;
    end
  end

  function automatic logic [6:0] link_addr_block(input logic [23:0] a);
    link_addr_block = a[fssm_pkg::ARRAY_MSB:fssm_pkg::BLOCK_SHIFT];
  endfunction : link_addr_block

  // Protection decode over 64KB block numbers
  logic [7:0] upper_first, lower_end, tgt_block;
  logic       tgt_prot, is_array_cmd, is_lock_cmd, stat_locked;

  assign tgt_block   = {1'b0, link_addr_block(laddr_q)};
  assign upper_first = fssm_pkg::NUM_BLOCKS - (8'h01 << (bp_q[2:0] - 3'h1));
  assign lower_end   = fssm_pkg::NUM_BLOCKS - (8'h40 >> bp_q[2:0]);
  assign tgt_prot    = bp_q[3] ? (tgt_block < lower_end)
                     : ((bp_q[2:0] != 3'h0) && (tgt_block >= upper_first));
  assign is_array_cmd = (lcode_q == fssm_pkg::CMD_PROG) || (lcode_q == fssm_pkg::CMD_SECT)
                     || (lcode_q == fssm_pkg::CMD_HALF) || (lcode_q == fssm_pkg::CMD_BLOCK)
                     || (lcode_q == fssm_pkg::CMD_CHIP);
  assign is_lock_cmd  = (lcode_q == fssm_pkg::CMD_SBLOCK) || (lcode_q == fssm_pkg::CMD_SBUNLK)
                     || (lcode_q == fssm_pkg::CMD_ALLLK) || (lcode_q == fssm_pkg::CMD_ALLUNL)
                     || (lcode_q == fssm_pkg::CMD_SECWR) || (lcode_q == fssm_pkg::CMD_SCHEME);
  assign stat_locked  = wp_low & lock_q;

  logic start_ok;
  assign start_ok = exec && !busy_q && wr_en_q && is_array_cmd
                 && ((lcode_q == fssm_pkg::CMD_CHIP) ? (bp_q == 4'h0) : !tgt_prot);

  // Busy flag follows the array engine only
  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (start_ok) begin
      busy_q <= 1'b1;
    end else if (op_done) begin
      busy_q <= 1'b0;
    end
  end

  // Write-enable latch, set by enable command, cleared by completions
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_en_q <= 1'b0;
    end else if (busy_q) begin
      if (op_done) begin
        wr_en_q <= 1'b0;
      end
    end else if (exec) begin
      if (lcode_q == fssm_pkg::CMD_WREN) begin
        wr_en_q <= 1'b1;
      end else if (lcode_q == fssm_pkg::CMD_WRDIS) begin
        wr_en_q <= 1'b0;
      end else if (lcode_q == fssm_pkg::CMD_STATWR && wr_en_q && !stat_locked) begin
        wr_en_q <= 1'b0;
      end else if (is_lock_cmd && wr_en_q) begin
        wr_en_q <= 1'b0;
      end
    end
  end

  // Non-volatile bits: restored once after reset, written by status write
  always_ff @(posedge core_clk) begin
    if (rst) begin
      restored_q <= 1'b0;
      bp_q       <= 4'h0;
      quad_en_q  <= 1'b0;
      lock_q     <= 1'b0;
      nv_write_q <= 1'b0;
      nv_value_q <= 6'h00;
    end else begin
      restored_q <= 1'b1;
      nv_write_q <= 1'b0;
      if (!restored_q) begin
        {lock_q, quad_en_q, bp_q} <= nv_restore;
      end else if (exec && !busy_q && wr_en_q && lcode_q == fssm_pkg::CMD_STATWR && !stat_locked) begin
        bp_q       <= ldata_q[fssm_pkg::BP_MSB:fssm_pkg::BP_LSB];
        quad_en_q  <= ldata_q[fssm_pkg::QUAD_POS];
        lock_q     <= ldata_q[fssm_pkg::LOCK_POS];
        nv_write_q <= 1'b1;
        nv_value_q <= ldata_q[fssm_pkg::LOCK_POS:fssm_pkg::BP_LSB];
      end
    end
  end

  assign status = {lock_q, quad_en_q, bp_q, wr_en_q, busy_q};

  // Job description to the array engine, split by erase granularity
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_start_q  <= 1'b0;
      op_kind_q   <= 4'h0;
      op_base_q   <= 24'h000000;
      op_sector_q <= 11'h000;
      op_half_q   <= 8'h00;
      op_block_q  <= 7'h00;
      op_data_q   <= 8'h00;
    end else begin
      op_start_q <= start_ok;
      if (start_ok) begin
        op_kind_q   <= lcode_q;
        op_data_q   <= ldata_q;
        op_base_q   <= {1'b0, laddr_q[fssm_pkg::ARRAY_MSB:fssm_pkg::SECTOR_SHIFT], 12'h000};
        op_sector_q <= laddr_q[fssm_pkg::ARRAY_MSB:fssm_pkg::SECTOR_SHIFT];
        op_half_q   <= laddr_q[fssm_pkg::ARRAY_MSB:fssm_pkg::HALF_SHIFT];
        op_block_q  <= link_addr_block(laddr_q);
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_stat_write;
    exec && !busy_q && lcode_q == fssm_pkg::CMD_STATWR;
  endsequence
  sequence s_array_req;
    exec && !busy_q && is_array_cmd;
  endsequence

  a_busy_on_start: assert property (start_ok |=> busy_q && op_start_q)
    else $error("busy not raised with op start");
  a_latch_done_clr: assert property (busy_q && op_done |=> !wr_en_q && !busy_q)
    else $error("latch or busy left set after completion");
  a_reject_no_latch: assert property (s_array_req and !wr_en_q |=> !op_start_q && !busy_q)
    else $error("array command taken with latch low");
  a_lock_refuse: assert property (s_stat_write and stat_locked |=> $stable(status[7:2]) && nv_write_q == 1'b0)
    else $error("status write taken while locked");
  a_stat_busy: assert property (s_stat_write |=> $stable(busy_q))
    else $error("status write moved busy");
  a_chip_clean: assert property (op_start_q && op_kind_q == fssm_pkg::CMD_CHIP |-> $past(bp_q) == 4'h0)
    else $error("chip erase with protection set");
  a_sector_base: assert property (op_start_q |-> op_base_q[11:0] == 12'h000 && op_base_q[22:12] == op_sector_q)
    else $error("sector base misaligned");
  a_block_split: assert property (op_start_q |-> op_block_q == op_sector_q[10:4] && op_half_q == op_sector_q[10:3])
    else $error("block or half index mismatch");
  a_lock_clear: assert property (exec && !busy_q && wr_en_q && is_lock_cmd |=> !wr_en_q)
    else $error("latch not cleared by lock command");
  a_lane_gate: assert property (@(posedge link_clk) disable iff (lrst_q)
    quad_data_lane2_oe |-> $past(link_status_q[fssm_pkg::QUAD_POS]))
    else $error("lane driven without quad enable");

endmodule : fssm_top
`default_nettype wire

/* sim/fssm_host_model.sv */
/*
  Host-side partner: issues decoded commands on link_clk and plays the array
  engine that answers every accepted job with one op_done pulse.
  Assumes both clocks run freely and the bench sets job_len per job.
*/
`timescale 1ns/1ps
`default_nettype none
module fssm_host_model (
  // Clocks
  input  wire logic        link_clk,
  input  wire logic        core_clk,
  // Command port
  output logic             link_cmd_valid,
  output logic      [3:0]  link_cmd_code,
  output logic      [7:0]  link_cmd_data,
  output logic      [23:0] link_cmd_addr,
  // Array engine
  input  wire logic        op_start_q,
  output logic             op_done
);
  int unsigned job_len = 2;

  initial begin
    link_cmd_valid = 1'b0;
    link_cmd_code  = 4'h0;
    link_cmd_data  = 8'h00;
    link_cmd_addr  = 24'h000000;
    op_done        = 1'b0;
  end

  task automatic send(input logic [3:0] c, input logic [7:0] d = 8'h00, input logic [23:0] a = 24'h000000);
    @(posedge link_clk);
    link_cmd_valid <= 1'b1;
    link_cmd_code  <= c;
    link_cmd_data  <= d;
    link_cmd_addr  <= a;
    @(posedge link_clk);
    link_cmd_valid <= 1'b0;
    // Released fields must not keep their value
    link_cmd_data  <= ~d;
    link_cmd_addr  <= ~a;
    // Long gap so the status poll sees the settled result
    repeat (6) @(posedge link_clk);
  endtask : send

  // Prompt or slow engine, chosen by job_len
  always @(posedge core_clk) begin
    if (op_start_q === 1'b1) begin
      repeat (job_len) @(posedge core_clk);
      op_done <= 1'b1;
      @(posedge core_clk);
      op_done <= 1'b0;
    end
  end
endmodule : fssm_host_model
`default_nettype wire

/* sim/testbench.sv */
/*
  Self-checking bench for fssm_top: the host model drives commands, monitors
  compare status polls and array jobs against queued expectations.
  Assumes fssm_pkg and fssm_top are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module testbench;
  logic        core_clk           = 1'b0;
  logic        link_clk           = 1'b0;
  logic        rst                = 1'b1;
  logic        quad_data_lane2_in = 1'b1;
  logic        link_cmd_valid, op_start_q, op_done;
  logic [3:0]  link_cmd_code, op_kind_q;
  logic [7:0]  link_cmd_data, link_status_q, op_half_q, op_data_q;
  logic [23:0] link_cmd_addr, op_base_q;
  logic [10:0] op_sector_q;
  logic [6:0]  op_block_q;
  logic [15:0] st_q[$];
  logic [27:0] job_q[$];
  logic [15:0] st_e;
  logic [27:0] jb;
  logic [49:0] jx;
  event        poll_ev;
  int          cmp_count  = 0;
  int          fail_count = 0;
  logic [3:0]  codes[6]   = '{fssm_pkg::CMD_SECT, fssm_pkg::CMD_HALF, fssm_pkg::CMD_BLOCK,
                              fssm_pkg::CMD_PROG, fssm_pkg::CMD_CHIP, fssm_pkg::CMD_SECT};
  logic [23:0] addrs[6]   = '{24'h02F000, 24'h02FFFF, 24'h7FFFFF, 24'h000000, 24'h000000, 24'h000000};
  logic [3:0]  clr[7]     = '{fssm_pkg::CMD_WRDIS, fssm_pkg::CMD_SBLOCK, fssm_pkg::CMD_SBUNLK,
                              fssm_pkg::CMD_ALLLK, fssm_pkg::CMD_ALLUNL, fssm_pkg::CMD_SECWR, fssm_pkg::CMD_SCHEME};

  initial forever #25 core_clk = ~core_clk;
  initial begin
    #13;
    forever #80 link_clk = ~link_clk;
  end

  fssm_host_model i_host (.link_clk(link_clk), .core_clk(core_clk), .link_cmd_valid(link_cmd_valid),
    .link_cmd_code(link_cmd_code), .link_cmd_data(link_cmd_data), .link_cmd_addr(link_cmd_addr),
    .op_start_q(op_start_q), .op_done(op_done));

  fssm_top i_dut (.core_clk(core_clk), .rst(rst), .link_clk(link_clk), .link_cmd_valid(link_cmd_valid),
    .link_cmd_code(link_cmd_code), .link_cmd_data(link_cmd_data), .link_cmd_addr(link_cmd_addr),
    .link_status_q(link_status_q), .link_lane_dout(2'b00), .link_lane_drive(1'b0), .link_lane_din_q(),
    .quad_data_lane2_in(quad_data_lane2_in), .quad_data_lane2_out(), .quad_data_lane2_oe(),
    .quad_data_lane3_in(1'b1), .quad_data_lane3_out(), .quad_data_lane3_oe(), .hold_n_q(),
    .op_start_q(op_start_q), .op_kind_q(op_kind_q), .op_base_q(op_base_q), .op_sector_q(op_sector_q),
    .op_half_q(op_half_q), .op_block_q(op_block_q), .op_data_q(op_data_q), .op_done(op_done),
    .nv_restore(6'h00), .nv_write_q(), .nv_value_q());

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic expect_st(input logic [7:0] m, input logic [7:0] v);
    @(negedge core_clk);
    st_q.push_back({m, v});
    -> poll_ev;
  endtask : expect_st

  task automatic job(input logic [3:0] c, input logic [23:0] a, input bit slow, input logic [7:0] st);
    i_host.job_len = slow ? 80 : 2;
    job_q.push_back({c, a});
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(c, 8'hA5, a);
    if (slow) expect_st(8'h03, 8'h03);
    for (int i = 0; i < 400 && link_status_q[0] !== 1'b0; i++) @(posedge core_clk);
    repeat (3) @(posedge link_clk);
    expect_st(8'hFF, st);
  endtask : job

  always @(poll_ev) begin
    st_e = st_q.pop_front();
    `CHK("status byte", st_e[7:0], link_status_q & st_e[15:8])
  end

  always @(posedge core_clk) begin
    if (op_start_q === 1'b1) begin
      if (job_q.size() == 0) `CHK("job accepted", 1'b0, 1'b1)
      else begin
        jb = job_q.pop_front();
        jx = {jb[22:12], jb[22:15], jb[22:16], 24'(jb[22:12]) * 24'h001000};
        `CHK("job kind", jb[27:24], op_kind_q)
        `CHK("job data", 8'hA5, op_data_q)
        if (jb[27:24] != fssm_pkg::CMD_CHIP) `CHK("job place", jx, {op_sector_q, op_half_q, op_block_q, op_base_q})
      end
    end
  end

  initial begin
    #500000;
    fail_count++;
    finish_test();
  end

  initial begin
    void'($urandom(21));
    addrs[4] = 24'($urandom);
    addrs[5] = 24'($urandom);
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge link_clk);
    expect_st(8'hFF, 8'h00);
    i_host.send(fssm_pkg::CMD_WREN);
    expect_st(8'hFF, 8'h02);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h7F);
    expect_st(8'hFF, 8'h7C);
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h00);
    // Latch now low: both jobs must be dropped
    i_host.send(fssm_pkg::CMD_SECT, 8'h00, 24'($urandom));
    i_host.send(fssm_pkg::CMD_CHIP);
    expect_st(8'hFF, 8'h00);
    for (int k = 0; k < 6; k++) job(codes[k], addrs[k], k[0], 8'h00);
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h04);
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_CHIP);
    i_host.send(fssm_pkg::CMD_SECT, 8'h00, 24'h7FF000);
    expect_st(8'hFF, 8'h06);
    job(fssm_pkg::CMD_SECT, 24'h001000, 1'b0, 8'h04);
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h84);
    @(posedge core_clk) quad_data_lane2_in <= 1'b0;
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h00);
    expect_st(8'hFC, 8'h84);
    @(posedge core_clk) quad_data_lane2_in <= 1'b1;
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'hC0);
    // Quad lanes on: the pin no longer arms the lock
    @(posedge core_clk) quad_data_lane2_in <= 1'b0;
    i_host.send(fssm_pkg::CMD_WREN);
    i_host.send(fssm_pkg::CMD_STATWR, 8'h00);
    expect_st(8'hFF, 8'h00);
    @(posedge core_clk) quad_data_lane2_in <= 1'b1;
    foreach (clr[i]) begin
      i_host.send(fssm_pkg::CMD_WREN);
      i_host.send(clr[i]);
      expect_st(8'h03, 8'h00);
    end
    repeat (2) @(posedge core_clk);
    `CHK("pending jobs", 32'd0, job_q.size())
    finish_test();
  end
endmodule : testbench
`default_nettype wire
